// file: sfch_handshake.v
// Serial flow control handshake: DTR drive and DSR transmit gating
//
// Functional notes
// - CTS always ignored; DSR ignored in native
// - Emulation hardware mode: DSR mark blocks transmit
// - Status replies transmit regardless of DSR
// - X-ON/X-OFF mode never samples DSR
// - Native hardware: DTR space when receive possible
// - Native X-ON/X-OFF: DTR space except init, selftest
// - Emulation hardware: DTR space ready, mark busy
// - Busy switch selects emulation busy conditions
// - Busy from reset until ready to receive
// - Busy during self-test printing, both settings
// - Busy when receive buffer full, always
// - Cover, paper end, macro, error: switch on
`include "sfch_map.vh"
`timescale 1ns/10ps
module sfch_handshake (
  clock,
  sys_rst,
  emulation_command_mode,
  handshake_xon_mode,
  busy_condition_switch,
  comm_enabled,
  self_test_active,
  rx_buffer_full,
  rx_can_accept,
  cover_open,
  paper_end_stop,
  macro_standby,
  error_active,
  dsr_in,
  cts_in,
  tx_request,
  tx_is_status_reply,
  tx_permit,
  dtr_out,
  rts_out,
  printer_busy
);
  input wire clock;
  input wire sys_rst;
  input wire emulation_command_mode;
  input wire handshake_xon_mode;
  input wire busy_condition_switch;
  input wire comm_enabled;
  input wire self_test_active;
  input wire rx_buffer_full;
  input wire rx_can_accept;
  input wire cover_open;
  input wire paper_end_stop;
  input wire macro_standby;
  input wire error_active;
  input wire dsr_in;
  input wire cts_in;
  input wire tx_request;
  input wire tx_is_status_reply;
  output wire tx_permit;
  output reg dtr_out;
  output wire rts_out;
  output reg printer_busy;

  reg mode_r;
  reg hs_r;
  reg cfg_done_r;
  reg dtr_nxt;
  reg busy_nxt;
  wire dsr_sync;
  wire dsr_blocks;

  localparam CAUSE_W = 4;
  wire emu_hw_sel;
  wire init_busy;
  wire test_busy;
  wire full_busy;
  wire switch_busy;
  wire dsr_mark;
  wire host_gate_open;
  wire status_bypass;
  wire [CAUSE_W-1:0] sw_cause;
  wire [CAUSE_W-1:0] sw_gated;
  genvar gi;

  // Pin from host crosses into the clock domain before use
  sfch_sync u_dsr_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in(dsr_in),
    .sync_out(dsr_sync)
  );

  // Modes are straps: caught once after reset, then held so that
  // a change mid-session cannot glitch the handshake
  always @(posedge clock) begin
    if (sys_rst) begin
      mode_r <= `SFCH_MODE_NATIVE;
      hs_r <= `SFCH_HS_HW;
    end else if (!cfg_done_r) begin
      mode_r <= emulation_command_mode;
      hs_r <= handshake_xon_mode;
    end
  end

  // One capture per reset; later strap moves are ignored
  always @(posedge clock) begin
    if (sys_rst) begin
      cfg_done_r <= `SFCH_CFG_RST;
    end else begin
      cfg_done_r <= 1'h1;
    end
  end

  // Decodes shared by several DTR mode branches
  function line_open;
    input cfg_ok;
    input comm_ok;
    input selftest;
    begin
      line_open = cfg_ok && comm_ok && !selftest;
    end
  endfunction

  function ready_level;
    input ready;
    begin
      if (ready) begin
        ready_level = `SFCH_SPACE;
      end else begin
        ready_level = `SFCH_MARK;
      end
    end
  endfunction

  // DSR only gates transmit in emulation hardware mode
  assign emu_hw_sel = (mode_r == `SFCH_MODE_EMUL) && (hs_r == `SFCH_HS_HW);

  // Each busy cause kept apart so the switch gates only the optional ones
  assign init_busy = !cfg_done_r || !comm_enabled;
  assign test_busy = self_test_active;
  assign full_busy = rx_buffer_full;
  // Optional causes: cover, paper end stop, macro wait, error
  assign sw_cause = {error_active, macro_standby, paper_end_stop, cover_open};

  generate
    for (gi = 0; gi < CAUSE_W; gi = gi + 1) begin : g_sw_gate
      assign sw_gated[gi] = busy_condition_switch && sw_cause[gi];
    end
  endgenerate

  assign switch_busy = |sw_gated;

  // Busy from the printer conditions; drives printer_busy in every mode, DTR in emulation hardware mode
  always @* begin
    busy_nxt = 1'h0;
    if (init_busy) begin
      busy_nxt = 1'h1;
    end
    if (test_busy) begin
      busy_nxt = 1'h1;
    end
    if (full_busy) begin
      busy_nxt = 1'h1;
    end
    if (switch_busy) begin
      busy_nxt = 1'h1;
    end
  end

  always @* begin
    dtr_nxt = `SFCH_MARK;
    case ({mode_r, hs_r})
      {`SFCH_MODE_NATIVE, `SFCH_HS_HW}: begin
        // Space only when data can be taken
        dtr_nxt = ready_level(line_open(cfg_done_r, comm_enabled, self_test_active) &&
          rx_can_accept && !rx_buffer_full);
      end
      {`SFCH_MODE_NATIVE, `SFCH_HS_XONXOFF}: begin
        dtr_nxt = ready_level(line_open(cfg_done_r, comm_enabled, self_test_active));
      end
      {`SFCH_MODE_EMUL, `SFCH_HS_HW}: begin
        dtr_nxt = ready_level(!busy_nxt);
      end
      {`SFCH_MODE_EMUL, `SFCH_HS_XONXOFF}: begin
        // Left open by the rules; mirrors native software flow
        dtr_nxt = ready_level(line_open(cfg_done_r, comm_enabled, self_test_active));
      end
      default: begin
        dtr_nxt = `SFCH_MARK;
      end
    endcase
  end

  // Ready line starts at mark so the host holds off until ready
  always @(posedge clock) begin
    if (sys_rst) begin
      dtr_out <= `SFCH_DTR_RST;
    end else begin
      dtr_out <= dtr_nxt;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      printer_busy <= `SFCH_BUSY_RST;
    end else begin
      printer_busy <= busy_nxt;
    end
  end

  // Return line follows the ready line
  assign rts_out = dtr_out;

  // CTS deliberately unread; DSR ignored outside emulation hardware mode
  assign dsr_mark = (dsr_sync == `SFCH_MARK);
  assign dsr_blocks = emu_hw_sel && dsr_mark;
  // DSR at space, or not consulted at all, opens the host gate
  assign host_gate_open = !dsr_blocks;
  // Status replies bypass the host gate so the host can poll once cfg_done_r is set
  assign status_bypass = tx_is_status_reply;
  assign tx_permit = tx_request && cfg_done_r && (status_bypass || host_gate_open);

endmodule // sfch_handshake

// file: sfch_map.vh
// Constant definitions for the serial flow control handshake block
`ifndef SFCH_MAP_VH
`define SFCH_MAP_VH
// Line levels: binary status of the serial control lines
`define SFCH_MARK 1'h1
`define SFCH_SPACE 1'h0
// Command-set mode encoding
`define SFCH_MODE_NATIVE 1'h0
`define SFCH_MODE_EMUL 1'h1
// Handshake mode encoding
`define SFCH_HS_HW 1'h0
`define SFCH_HS_XONXOFF 1'h1
// Reset values
`define SFCH_DTR_RST 1'h1
`define SFCH_CFG_RST 1'h0
`define SFCH_BUSY_RST 1'h1
`endif

// file: sfch_sync.v
// Two-flop synchroniser for asynchronous pin inputs
`include "sfch_map.vh"
`timescale 1ns/10ps
module sfch_sync (
  clock,
  sys_rst,
  async_in,
  sync_out
);
  input wire clock;
  input wire sys_rst;
  input wire async_in;
  output reg sync_out;
  reg meta_r;
  always @(posedge clock) begin
    if (sys_rst) begin
      meta_r <= `SFCH_MARK;
      sync_out <= `SFCH_MARK;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // sfch_sync

// file: sfch_host.sv
// Host serial port model driving the handshake inputs
`timescale 1ns/10ps
module sfch_host (
  input wire clock,
  input wire dsr_block,
  output logic dsr_in,
  output logic cts_in
);
  initial dsr_in = 1'b1;
  initial cts_in = 1'b0;
  // Mark forbids the device to send, space permits
  always @(negedge clock) dsr_in <= dsr_block;
  // Toggles every cycle so any use of it shows
  always @(negedge clock) cts_in <= ~cts_in;
endmodule // sfch_host

// file: sfch_asserts.sv
// Port checker for the handshake block
`timescale 1ns/10ps
module sfch_chk (
  input wire clock, sys_rst, emulation_command_mode, handshake_xon_mode, comm_enabled,
  input wire self_test_active, rx_buffer_full, tx_request, tx_is_status_reply, tx_permit, dtr_out, rts_out,
  input wire dsr_in
);
  // Straps settle one edge after release
  logic up_r = 1'b0;
  always @(posedge clock) up_r <= !sys_rst;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_rts_tracks: assert property (rts_out == dtr_out) else $error("rts differs");
  a_reset_busy: assert property (disable iff (1'b0) sys_rst |=> dtr_out) else $error("no busy");
  a_nocomm_busy: assert property (!comm_enabled |=> dtr_out) else $error("no busy");
  a_test_busy: assert property (self_test_active |=> dtr_out) else $error("no busy");
  a_full_busy: assert property (rx_buffer_full && !handshake_xon_mode |=> dtr_out) else $error("no busy");
  a_xon_space: assert property (handshake_xon_mode && comm_enabled && !self_test_active |=> !dtr_out)
    else $error("not space");
  a_status_sent: assert property (up_r && tx_request && tx_is_status_reply |-> tx_permit)
    else $error("held");
  a_native_free: assert property (up_r && tx_request && !emulation_command_mode |-> tx_permit)
    else $error("held");
  a_dsr_holds: assert property (up_r && tx_request && !tx_is_status_reply && emulation_command_mode &&
    !handshake_xon_mode && $past(dsr_in, 2) |-> !tx_permit) else $error("sent on mark");
  a_xon_free: assert property (up_r && tx_request && handshake_xon_mode |-> tx_permit)
    else $error("held");
endmodule // sfch_chk
bind sfch_handshake sfch_chk i_sfch_chk (.*);

// file: serial_flow_control_handshake_tb.sv
// Testbench for the handshake block
`timescale 1ns/10ps
module serial_flow_control_handshake_tb;
  logic clock = 0, rst = 1, emu = 0, xon = 0, sw = 0, comm = 0, st = 0, full = 0, acc = 1, cov = 0, stat = 0, blk = 1;
  logic req = 1, pap = 0, mac = 0, ero = 0;
  logic dsr, cts, pmt, dtr, rts, bsy;
  int err_total = 0, n_compared = 0;
  sfch_host i_sfch_host (.clock(clock), .dsr_block(blk), .dsr_in(dsr), .cts_in(cts));
  sfch_handshake i_sfch_handshake (.clock(clock), .sys_rst(rst), .emulation_command_mode(emu),
    .handshake_xon_mode(xon), .busy_condition_switch(sw), .comm_enabled(comm), .self_test_active(st),
    .rx_buffer_full(full), .rx_can_accept(acc), .cover_open(cov), .paper_end_stop(pap), .macro_standby(mac),
    .error_active(ero), .dsr_in(dsr), .cts_in(cts), .tx_request(req), .tx_is_status_reply(stat),
    .tx_permit(pmt), .dtr_out(dtr), .rts_out(rts), .printer_busy(bsy));
  initial forever #20 clock = ~clock;
  task chk(string n, logic v, logic e);
    n_compared++;
    if (v !== e) begin
      err_total++;
      $display("MISMATCH %s exp %b seen %b", n, e, v);
    end
  endtask
  task stop_test;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task cyc(int n);
    repeat (n) @(negedge clock);
  endtask
  initial begin
    for (int m = 0; m < 4; m++) begin
      rst = 1;
      {emu, xon} = m[1:0];
      comm = 0;
      cyc(8);
      chk("dtr", dtr, 1);
      chk("busy", bsy, 1);
      rst = 0;
      cyc(3);
      chk("dtr", dtr, 1);
      chk("busy", bsy, 1);
      comm = 1;
      cyc(2);
      chk("dtr", dtr, 0);
      chk("rts", rts, 0);
      chk("busy", bsy, 0);
      chk("permit", pmt, !(emu && !xon));
      stat = 1;
      req = 0;
      cyc(1);
      chk("permit", pmt, 0);
      req = 1;
      cyc(1);
      chk("permit", pmt, 1);
      stat = 0;
      blk = 0;
      cyc(3);
      chk("permit", pmt, 1);
      blk = 1;
      cov = 1;
      cyc(3);
      chk("permit", pmt, !(emu && !xon));
      chk("dtr", dtr, 0);
      chk("busy", bsy, 0);
      sw = 1;
      cyc(2);
      chk("dtr", dtr, emu && !xon);
      chk("busy", bsy, 1);
      {cov, pap} = 2'b01;
      cyc(2);
      chk("busy", bsy, 1);
      {pap, mac} = 2'b01;
      cyc(2);
      chk("busy", bsy, 1);
      {mac, ero} = 2'b01;
      cyc(2);
      chk("busy", bsy, 1);
      {ero, sw, st} = 3'b001;
      cyc(2);
      chk("dtr", dtr, 1);
      chk("busy", bsy, 1);
      {st, full} = 2'b01;
      cyc(2);
      chk("dtr", dtr, !xon);
      chk("busy", bsy, 1);
      {full, acc} = 2'b00;
      cyc(2);
      if (!emu && !xon) chk("dtr", dtr, 1);
      chk("busy", bsy, 0);
      acc = 1;
    end
    stop_test;
  end
  // Run needs about 140 cycles
  initial begin
    #100000;
    err_total++;
    stop_test;
  end
endmodule // serial_flow_control_handshake_tb
